// ---- verilog/ebc_pkg.sv ----
package ebc_pkg;
   // Bus and bank geometry
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int NUM_SRC = 64;
   localparam int SRC_W = 6;
   localparam int LOG_W = 64;
   localparam int INFO_W = 63;
   localparam int VALID_BIT = 63;
   // Register indices as numbered in the model-specific space
   localparam logic [ADDR_W-1:0] IDX_ENABLE = 16'h0400;
   localparam logic [ADDR_W-1:0] IDX_LOG = 16'h0401;
   // Byte addresses: low words at four times the index
   localparam logic [ADDR_W-1:0] ADDR_ENABLE_LO = 16'(IDX_ENABLE * 4);
   localparam logic [ADDR_W-1:0] ADDR_LOG_LO = 16'(IDX_LOG * 4);
   // High words sit in a second window above the low words
   localparam logic [ADDR_W-1:0] HI_WINDOW = 16'h1000;
   localparam logic [ADDR_W-1:0] ADDR_ENABLE_HI = 16'(ADDR_ENABLE_LO + HI_WINDOW);
   localparam logic [ADDR_W-1:0] ADDR_LOG_HI = 16'(ADDR_LOG_LO + HI_WINDOW);
   // Interrupt status and mask
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STS = 16'h3000;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MSK = 16'h3004;
   // Interrupt event bit positions
   localparam int EV_LOG = 0;
   localparam int EV_MCE = 1;
   localparam int EV_GPF = 2;
   localparam int EV_W = 3;
   // Reset values
   localparam logic [LOG_W-1:0] ENABLE_RST = 64'h0;
   localparam logic [LOG_W-1:0] LOG_RST = 64'h0;
   localparam logic [EV_W-1:0] IRQ_RST = 3'h0;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0;

   // One error report from a hardware detector
   typedef struct packed {
      logic valid;
      logic [SRC_W-1:0] src;
      logic [INFO_W-1:0] info;
   } ebc_err_type;
endpackage

// ---- verilog/ebc_bank.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// - one enable bit per source, writable
// - detected error logged into an empty log, valid flag set
// - logging ignores the enable mask
// - exception raised only for enabled sources
// - nonzero log write faults; zero clears
// - enable mask index 400h, log follows
module ebc_bank
   import ebc_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [DATA_W-1:0] pwdata_i,
   output logic [DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire ebc_err_type err_i,
   output logic machine_check_exception_o,
   output logic general_protection_fault_o,
   output logic irq_o
);

   logic [LOG_W-1:0] bank_source_enable_mask_r;
   logic [LOG_W-1:0] bank_source_enable_mask_nxt;
   logic [LOG_W-1:0] bank_error_log_r;
   logic [LOG_W-1:0] bank_error_log_nxt;
   logic [EV_W-1:0] irq_sts_r;
   logic [EV_W-1:0] irq_sts_nxt;
   logic [EV_W-1:0] irq_msk_r;
   logic mce_r;
   logic gpf_r;
   logic [DATA_W-1:0] rd_word;
   logic [DATA_W-1:0] prdata_nxt;
   logic [DATA_W-1:0] prdata_r;

   // Address decode; the slave never waits
   wire logic acc = psel_i & penable_i;
   wire logic wr = acc & pwrite_i;
   wire logic req_setup = psel_i & ~penable_i;
   wire logic sel_en_lo = (paddr_i == ADDR_ENABLE_LO);
   wire logic sel_en_hi = (paddr_i == ADDR_ENABLE_HI);
   wire logic sel_log_lo = (paddr_i == ADDR_LOG_LO);
   wire logic sel_log_hi = (paddr_i == ADDR_LOG_HI);
   wire logic sel_sts = (paddr_i == ADDR_IRQ_STS);
   wire logic sel_msk = (paddr_i == ADDR_IRQ_MSK);
   wire logic mapped = sel_en_lo | sel_en_hi | sel_log_lo | sel_log_hi |
                       sel_sts | sel_msk;
   wire logic wdata_zero = (pwdata_i == DATA_ZERO);

   // Log writes: only zero is accepted, anything else faults
   wire logic log_wr = wr & (sel_log_lo | sel_log_hi);
   wire logic gpf_req = log_wr & ~wdata_zero;
   wire logic clr_lo = wr & sel_log_lo & wdata_zero;
   wire logic clr_hi = wr & sel_log_hi & wdata_zero;

   // Capture only into an empty log; a full log keeps the older error
   wire logic log_take = err_i.valid & ~bank_error_log_r[VALID_BIT];
   // Exception depends on the source enable, logging does not
   wire logic mce_hit = err_i.valid & bank_source_enable_mask_r[err_i.src];

   wire logic [EV_W-1:0] events;
   assign events[EV_LOG] = log_take;
   assign events[EV_MCE] = mce_hit;
   assign events[EV_GPF] = gpf_req;
   wire logic [EV_W-1:0] irq_w1c =
      (wr & sel_sts) ? pwdata_i[EV_W-1:0] : IRQ_RST;

   // Enable mask next value, written one word at a time
   always_comb begin
      bank_source_enable_mask_nxt = bank_source_enable_mask_r;
      if (wr && sel_en_lo) begin
         bank_source_enable_mask_nxt[DATA_W-1:0] = pwdata_i;
      end
      if (wr && sel_en_hi) begin
         bank_source_enable_mask_nxt[LOG_W-1:DATA_W] = pwdata_i;
      end
   end

   // Log next value: a new capture wins over a same-cycle clear
   always_comb begin
      bank_error_log_nxt = bank_error_log_r;
      if (clr_lo) begin
         bank_error_log_nxt[DATA_W-1:0] = DATA_ZERO;
      end
      if (clr_hi) begin
         bank_error_log_nxt[LOG_W-1:DATA_W] = DATA_ZERO;
      end
      if (log_take) begin
         bank_error_log_nxt = {1'b1, err_i.info};
      end
   end

   // Sticky interrupt status; set beats write-one-to-clear
   assign irq_sts_nxt = (irq_sts_r & ~irq_w1c) | events;

   // Register bank
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         bank_source_enable_mask_r <= ENABLE_RST;
         bank_error_log_r <= LOG_RST;
         irq_sts_r <= IRQ_RST;
         irq_msk_r <= IRQ_RST;
         prdata_r <= DATA_ZERO;
      end else begin
         bank_source_enable_mask_r <= bank_source_enable_mask_nxt;
         bank_error_log_r <= bank_error_log_nxt;
         irq_sts_r <= irq_sts_nxt;
         prdata_r <= prdata_nxt;
         if (wr && sel_msk) begin
            irq_msk_r <= pwdata_i[EV_W-1:0];
         end
      end
   end

   // Exception and fault leave as registered one-cycle pulses
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         mce_r <= 1'b0;
         gpf_r <= 1'b0;
      end else begin
         mce_r <= mce_hit;
         gpf_r <= gpf_req;
      end
   end

   // Read mux; unmapped reads return zero with an error
   always_comb begin
      rd_word = DATA_ZERO;
      if (sel_en_lo) begin
         rd_word = bank_source_enable_mask_r[DATA_W-1:0];
      end else if (sel_en_hi) begin
         rd_word = bank_source_enable_mask_r[LOG_W-1:DATA_W];
      end else if (sel_log_lo) begin
         rd_word = bank_error_log_r[DATA_W-1:0];
      end else if (sel_log_hi) begin
         rd_word = bank_error_log_r[LOG_W-1:DATA_W];
      end else if (sel_sts) begin
         rd_word = {{(DATA_W-EV_W){1'b0}}, irq_sts_r};
      end else if (sel_msk) begin
         rd_word = {{(DATA_W-EV_W){1'b0}}, irq_msk_r};
      end
   end

   // Read data is caught in the setup cycle so it leaves a flip-flop;
   // a capture at that same edge shows only on the next read
   assign prdata_nxt = req_setup ? rd_word : prdata_r;
   assign prdata_o = prdata_r;

   assign pready_o = 1'b1;
   // A faulting log write is also flagged on the bus
   assign pslverr_o = acc & (~mapped | gpf_req);
   assign machine_check_exception_o = mce_r;
   assign general_protection_fault_o = gpf_r;
   assign irq_o = |(irq_sts_r & irq_msk_r);

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   enable_write_lo_a: assert property (
      wr && sel_en_lo |=> bank_source_enable_mask_r[DATA_W-1:0] ==
                          $past(pwdata_i))
      else $error("enable mask low word not written");

   log_capture_a: assert property (
      err_i.valid && !bank_error_log_r[VALID_BIT] |=>
         bank_error_log_r == {1'b1, $past(err_i.info)})
      else $error("error not captured into log");

   log_no_enable_a: assert property (
      err_i.valid && !bank_error_log_r[VALID_BIT] &&
      !bank_source_enable_mask_r[err_i.src] |=> bank_error_log_r[VALID_BIT])
      else $error("disabled source error not logged");

   mce_enabled_a: assert property (
      err_i.valid && bank_source_enable_mask_r[err_i.src] |=>
         machine_check_exception_o)
      else $error("enabled source did not raise exception");

   mce_masked_a: assert property (
      !(err_i.valid && bank_source_enable_mask_r[err_i.src]) |=>
         !machine_check_exception_o)
      else $error("exception without enabled error");

   nonzero_fault_a: assert property (
      log_wr && !wdata_zero |-> pslverr_o ##1
         (general_protection_fault_o && (bank_error_log_r ==
          $past(bank_error_log_r) || $past(log_take))))
      else $error("nonzero log write did not fault");

   zero_clear_a: assert property (
      wr && sel_log_hi && wdata_zero && !err_i.valid |=>
         !bank_error_log_r[VALID_BIT] && !general_protection_fault_o)
      else $error("zero write did not clear valid");

   valid_hold_a: assert property (
      bank_error_log_r[VALID_BIT] && !clr_hi |=>
         bank_error_log_r[VALID_BIT] && $stable(bank_error_log_r[INFO_W-1:0])
         || $past(clr_lo))
      else $error("valid log changed without clear");

   log_addr_a: assert property (
      acc && !pwrite_i && sel_log_hi |->
         prdata_o == $past(bank_error_log_r[LOG_W-1:DATA_W]) && !pslverr_o)
      else $error("log high word read mismatch");

   cov_log_c: cover property (log_take ##1 irq_o);
   cov_overflow_c: cover property (err_i.valid && bank_error_log_r[VALID_BIT]);
   cov_capture_clear_c: cover property (log_take && clr_hi);
   cov_fault_c: cover property (gpf_req ##1 general_protection_fault_o);
endmodule

// ---- testbench/ebc_detector.sv ----
`timescale 1ns/100ps
// Hardware error detector on the far side of the bank
module ebc_detector
   import ebc_pkg::*;
(
   input wire logic clk_i,
   output ebc_err_type err_o
);
   initial err_o = '0;

   // One-cycle report; released fields show inverted junk, never held data
   task automatic fire(input logic [SRC_W-1:0] s, input logic [INFO_W-1:0] f);
      @(posedge clk_i) err_o <= {1'b1, s, f};
      @(posedge clk_i) err_o <= {1'b0, ~s, ~f};
   endtask
endmodule

// ---- testbench/ebc_bank_tb_top.sv ----
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; \
   $display("MISMATCH %s exp %h got %h", n, e, s); end end
module ebc_bank_tb_top
   import ebc_pkg::*;
;
   logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0, prdata, rdat;
   logic pready, pslverr, rerr, mce, gpf, irq;
   ebc_err_type err;
   int errors = 0, checks = 0, cyc = 0;

   always #2 clk = ~clk;
   ebc_detector det (.clk_i(clk), .err_o(err));
   ebc_bank dut (.clk_i(clk), .nrst_i(nrst), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .err_i(err), .machine_check_exception_o(mce),
      .general_protection_fault_o(gpf), .irq_o(irq));

   // Print counts and verdict, then stop
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Hang guard: the whole sequence needs well under 200 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         errors++;
         give_verdict();
      end
   end

   // APB transfer; waits for pready, no assumed latency
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
      @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk) penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Enable all sources but 33, which stands for a corrected-only source
   task automatic t_enable();
      apb(1, ADDR_ENABLE_LO, 32'hffffffff);
      apb(1, ADDR_ENABLE_HI, 32'hfffffffd);
      apb(0, ADDR_ENABLE_LO, '0);
      `CHK("en_lo", 32'hffffffff, rdat)
      apb(0, ADDR_ENABLE_HI, '0);
      `CHK("en_hi", 32'hfffffffd, rdat)
   endtask

   // Disabled source logs silently; a second error keeps the first log
   task automatic t_log();
      det.fire(6'd33, 63'h1234_5678_9abc_def0);
      #1 `CHK("mce_off", 1'b0, mce)
      apb(0, ADDR_LOG_HI, '0);
      `CHK("log_hi", 32'h92345678, rdat)
      apb(0, ADDR_LOG_LO, '0);
      `CHK("log_lo", 32'h9abcdef0, rdat)
      det.fire(6'd5, 63'h0);
      #1 `CHK("mce_on", 1'b1, mce)
      apb(0, ADDR_LOG_HI, '0);
      `CHK("log_keep", 32'h92345678, rdat)
   endtask

   // Nonzero log write faults; zero clears after the log was saved
   task automatic t_fault();
      apb(1, ADDR_LOG_LO, 32'h1);
      `CHK("nz_err", 1'b1, rerr)
      #1 `CHK("gpf", 1'b1, gpf)
      apb(1, ADDR_LOG_LO, '0);
      `CHK("z_err", 1'b0, rerr)
      apb(1, ADDR_LOG_HI, '0);
      apb(0, ADDR_LOG_HI, '0);
      `CHK("log_clr", 32'h0, rdat)
   endtask

   // Status, mask, write-one-to-clear and an unmapped access
   task automatic t_irq();
      apb(0, ADDR_IRQ_STS, '0);
      `CHK("sts", 32'h7, rdat)
      `CHK("irq_msk", 1'b0, irq)
      apb(1, ADDR_IRQ_MSK, 32'h2);
      #1 `CHK("irq_on", 1'b1, irq)
      apb(1, ADDR_IRQ_STS, 32'h2);
      #1 `CHK("irq_off", 1'b0, irq)
      apb(0, ADDR_IRQ_STS, '0);
      `CHK("sts_w1c", 32'h5, rdat)
      apb(0, 16'h0f00, '0);
      `CHK("unmap", 1'b1, rerr)
   endtask

   // Reset for four cycles, then the scenarios
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      t_enable();
      t_log();
      t_fault();
      t_irq();
      give_verdict();
   end
endmodule
